/* File: dms_top.sv */
// drive mode selector: decodes the gear selector, key wake, charge port and
// emergency disconnect into an operating state and motoring limits.
// assumes switch inputs already conditioned to logic levels and synchronous to pclk.
`timescale 1ns/1ps
module dms_top #(
  parameter logic [15:0] low_rpm_default = dms_pkg::rpm_low_reset,
  parameter logic [15:0] maxregen_rpm_default = dms_pkg::rpm_maxregen_reset
) (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // vehicle switches
  input wire logic gear_code_bit_a,
  input wire logic gear_code_bit_b,
  input wire logic gear_code_bit_c,
  input wire logic gear_code_parity,
  input wire logic key_wake_in,
  input wire logic charge_port_present,
  input wire logic emergency_disconnect,
  // drive control outputs
  output logic motoring_enable,
  output logic charging_enable,
  output logic ac_charge_allow,
  output logic propulsion_enable,
  output logic signed [7:0] regen_drag,
  output logic brake_torque_en,
  output logic [7:0] accel_torque_limit,
  output logic [15:0] rpm_limit,
  output logic irq
);

  localparam int iw = dms_pkg::irq_width;

  // gear selector decode
  wire logic [3:0] gear_selector = {gear_code_bit_a, gear_code_bit_b,
                                    gear_code_bit_c, gear_code_parity};
  wire logic parity_ok = ~^gear_selector;

  // parity is checked before the table so one flipped line never lands on a mode
  function automatic dms_pkg::dms_mode_type decode_mode(input logic [3:0] code);
    if (^code) begin
      decode_mode = dms_pkg::dms_invalid;
    end else begin
      case (code)
        4'hf: decode_mode = dms_pkg::dms_park;
        4'h6: decode_mode = dms_pkg::dms_reverse;
        4'h3: decode_mode = dms_pkg::dms_neutral;
        4'ha: decode_mode = dms_pkg::dms_drive;
        4'h9: decode_mode = dms_pkg::dms_low;
        4'hc: decode_mode = dms_pkg::dms_maxregen;
        default: decode_mode = dms_pkg::dms_invalid;
      endcase
    end
  endfunction

  wire dms_pkg::dms_mode_type sel_mode = decode_mode(gear_selector);
  wire logic sel_valid = (sel_mode != dms_pkg::dms_invalid) && parity_ok;

  // registers
  // no speed sensor here: software must keep the moving bit current
  logic moving;
  logic [7:0] ramp_step;
  logic [15:0] low_rpm;
  logic [15:0] maxregen_rpm;
  logic [iw-1:0] irq_stat;
  logic [iw-1:0] irq_mask;
  dms_pkg::dms_mode_type mode;
  dms_pkg::dms_state_type state;
  dms_pkg::dms_state_type next_state;
  logic key_prev;
  logic cp_prev;
  logic disc_prev;
  logic [7:0] accel_level;

  // invalid codes count as parked, so a broken selector harness still allows charging
  wire logic parked = (mode == dms_pkg::dms_park) || (mode == dms_pkg::dms_invalid);
  wire logic parked_or_neutral = parked || (mode == dms_pkg::dms_neutral);

  // sub-mode settings table
  function automatic dms_pkg::dms_setting_type mode_setting(
      input dms_pkg::dms_mode_type m, input logic [15:0] low_lim, input logic [15:0] max_lim);
    mode_setting = '{dms_pkg::regen_none, 1'b0, 1'b0, 1'b0, dms_pkg::rpm_none};
    case (m)
      dms_pkg::dms_reverse: begin
        mode_setting = '{dms_pkg::regen_rev, 1'b1, 1'b1, 1'b0, dms_pkg::rpm_rev};
      end
      dms_pkg::dms_neutral: begin
        mode_setting = '{dms_pkg::regen_none, 1'b1, 1'b0, 1'b1, dms_pkg::rpm_none};
      end
      dms_pkg::dms_drive: begin
        mode_setting = '{dms_pkg::regen_drive, 1'b1, 1'b1, 1'b0, dms_pkg::rpm_drive};
      end
      dms_pkg::dms_low: begin
        mode_setting = '{dms_pkg::regen_low, 1'b1, 1'b1, 1'b0, low_lim};
      end
      dms_pkg::dms_maxregen: begin
        mode_setting = '{dms_pkg::regen_max, 1'b1, 1'b1, 1'b0, max_lim};
      end
      default: begin
        // park and invalid codes: all torque off, no drag, no limit
        mode_setting = '{dms_pkg::regen_none, 1'b0, 1'b0, 1'b0, dms_pkg::rpm_none};
      end
    endcase
  endfunction

  wire dms_pkg::dms_setting_type setting = mode_setting(mode, low_rpm, maxregen_rpm);

  // operating state
  wire logic cp_rise = charge_port_present & ~cp_prev;
  always_comb begin
    next_state = state;
    case (state)
      dms_pkg::dms_off: begin
        if (key_wake_in) begin
          next_state = dms_pkg::dms_motoring;
        end
      end
      dms_pkg::dms_motoring: begin
        if (!key_wake_in) begin
          next_state = dms_pkg::dms_off;
        end
      end
      dms_pkg::dms_charging: begin
        // leaving charge returns to motoring only with the key still on
        if (!charge_port_present) begin
          next_state = key_wake_in ? dms_pkg::dms_motoring : dms_pkg::dms_off;
        end
      end
      default: begin
        // leave disconnect only once the switch is back at ground and key cycled off
        if (!emergency_disconnect && !key_wake_in) begin
          next_state = dms_pkg::dms_off;
        end
      end
    endcase
    // charge request taken on the edge and while held, once conditions allow
    if (state != dms_pkg::dms_disconnected && charge_port_present &&
        parked_or_neutral && !moving) begin
      next_state = dms_pkg::dms_charging;
    end
    if (emergency_disconnect) begin
      next_state = dms_pkg::dms_disconnected;
    end
  end

  // a ramped level makes neutral bleed torque off instead of dropping it
  wire logic [7:0] accel_target = (state == dms_pkg::dms_motoring && setting.accel_en) ?
                                  dms_pkg::accel_full : 8'h00;
  wire logic [7:0] next_accel_level =
      (accel_target != 8'h00) ? accel_target :
      (setting.ramp_down && accel_level > ramp_step) ? accel_level - ramp_step : 8'h00;

  // apb decode; zero wait states
  wire logic apb_wr = psel & penable & pwrite;
  wire logic apb_rd_setup = psel & ~penable & ~pwrite;
  wire logic hit_ctrl = (paddr == dms_pkg::ctrl_addr);
  wire logic hit_status = (paddr == dms_pkg::status_addr);
  wire logic hit_istat = (paddr == dms_pkg::irq_stat_addr);
  wire logic hit_imask = (paddr == dms_pkg::irq_mask_addr);
  wire logic hit_limits = (paddr == dms_pkg::limits_addr);
  wire logic hit_any = hit_ctrl | hit_status | hit_istat | hit_imask | hit_limits;

  // write strobes, one per writable register
  wire logic wr_ctrl = apb_wr & hit_ctrl;
  wire logic wr_istat = apb_wr & hit_istat;
  wire logic wr_imask = apb_wr & hit_imask;
  wire logic wr_limits = apb_wr & hit_limits;

  wire logic [31:0] status_word = {16'h0000, 5'h00, sel_valid, 2'(state),
                                   1'b0, 3'(mode), gear_selector};
  wire logic [31:0] ctrl_word = {16'h0000, ramp_step, 7'h00, moving};
  wire logic [31:0] istat_word = {{(32-iw){1'b0}}, irq_stat};
  wire logic [31:0] imask_word = {{(32-iw){1'b0}}, irq_mask};
  wire logic [31:0] limits_word = {maxregen_rpm, low_rpm};
  logic [31:0] rd_mux;
  always_comb begin
    if (hit_ctrl) begin
      rd_mux = ctrl_word;
    end else if (hit_status) begin
      rd_mux = status_word;
    end else if (hit_istat) begin
      rd_mux = istat_word;
    end else if (hit_imask) begin
      rd_mux = imask_word;
    end else if (hit_limits) begin
      rd_mux = limits_word;
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  // events; set wins over a write-one clear
  wire logic [iw-1:0] irq_event;
  assign irq_event[dms_pkg::irq_mode_bit] = (sel_mode != mode);
  assign irq_event[dms_pkg::irq_invalid_bit] = ~sel_valid & (mode != dms_pkg::dms_invalid);
  assign irq_event[dms_pkg::irq_wake_bit] = key_wake_in ^ key_prev;
  assign irq_event[dms_pkg::irq_disc_bit] = emergency_disconnect & ~disc_prev;
  assign irq_event[dms_pkg::irq_charge_bit] = cp_rise;
  wire logic [iw-1:0] irq_clear = wr_istat ? pwdata[iw-1:0] : {iw{1'b0}};
  wire logic [iw-1:0] next_irq_stat = (irq_stat & ~irq_clear) | irq_event;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= dms_pkg::dms_off;
      mode <= dms_pkg::dms_invalid;
      key_prev <= 1'b0;
      cp_prev <= 1'b0;
      disc_prev <= 1'b0;
      accel_level <= 8'h00;
    end else begin
      state <= next_state;
      mode <= sel_mode;
      key_prev <= key_wake_in;
      cp_prev <= charge_port_present;
      disc_prev <= emergency_disconnect;
      accel_level <= next_accel_level;
    end
  end

  // control and limit registers; limit defaults load one edge after reset release
  logic limits_loaded;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      moving <= 1'b0;
      ramp_step <= dms_pkg::ramp_step_reset;
      low_rpm <= 16'h0000;
      maxregen_rpm <= 16'h0000;
      limits_loaded <= 1'b0;
    end else begin
      if (!limits_loaded) begin
        low_rpm <= low_rpm_default;
        maxregen_rpm <= maxregen_rpm_default;
        limits_loaded <= 1'b1;
      end else if (wr_limits) begin
        low_rpm <= pwdata[15:0];
        maxregen_rpm <= pwdata[31:16];
      end
      if (wr_ctrl) begin
        moving <= pwdata[dms_pkg::ctrl_moving_bit];
        ramp_step <= pwdata[dms_pkg::ctrl_ramp_step_lsb +: 8];
      end
    end
  end

  // interrupt status and mask; a clear never hides an event of the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= {iw{1'b0}};
      irq_mask <= dms_pkg::irq_mask_reset;
    end else begin
      irq_stat <= next_irq_stat;
      if (wr_imask) begin
        irq_mask <= pwdata[iw-1:0];
      end
    end
  end

  // registered outputs; next values are named so the flops stay plain copies
  // setting-based outputs lag the selector by two edges, state outputs by one
  wire logic run = (next_state == dms_pkg::dms_motoring);
  wire logic to_charging = (next_state == dms_pkg::dms_charging);
  wire logic next_motoring_enable = run;
  wire logic next_charging_enable = to_charging;
  wire logic next_ac_charge_allow = to_charging && (sel_mode == dms_pkg::dms_park) &&
                                    !key_wake_in;
  wire logic next_propulsion_enable = run && !emergency_disconnect;

  // torque settings only while motoring
  wire logic signed [7:0] next_regen_drag = run ? setting.regen : dms_pkg::regen_none;
  wire logic next_brake_torque_en = run && setting.brake_en;
  // disconnect cuts torque at once; the ramp level itself settles on its own
  wire logic [7:0] next_accel_torque_limit = emergency_disconnect ? 8'h00 :
                                             next_accel_level;
  wire logic [15:0] next_rpm_limit = setting.rpm_limit;
  wire logic next_irq = |(next_irq_stat & irq_mask);

  // apb answer: zero wait states, ready and error flag in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      if (apb_rd_setup) begin
        prdata <= rd_mux;
      end
    end
  end

  // drive control outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motoring_enable <= 1'b0;
      charging_enable <= 1'b0;
      ac_charge_allow <= 1'b0;
      propulsion_enable <= 1'b0;
      regen_drag <= dms_pkg::regen_none;
      brake_torque_en <= 1'b0;
      accel_torque_limit <= 8'h00;
      rpm_limit <= dms_pkg::rpm_none;
      irq <= 1'b0;
    end else begin
      motoring_enable <= next_motoring_enable;
      charging_enable <= next_charging_enable;
      ac_charge_allow <= next_ac_charge_allow;
      propulsion_enable <= next_propulsion_enable;
      regen_drag <= next_regen_drag;
      brake_torque_en <= next_brake_torque_en;
      accel_torque_limit <= next_accel_torque_limit;
      rpm_limit <= next_rpm_limit;
      irq <= next_irq;
    end
  end

endmodule

/* File: dms_pkg.sv */
// drive mode selector package: register map, field layouts, sub-mode settings
// assumes a 32-bit apb slave clocked by pclk at 250 mhz
package dms_pkg;

  localparam logic [11:0] ctrl_addr = 12'h000;
  localparam logic [11:0] status_addr = 12'h004;
  localparam logic [11:0] irq_stat_addr = 12'h008;
  localparam logic [11:0] irq_mask_addr = 12'h00c;
  localparam logic [11:0] limits_addr = 12'h010;

  // ctrl fields
  localparam int ctrl_moving_bit = 0;
  localparam int ctrl_ramp_step_lsb = 8;
  localparam logic [7:0] ramp_step_reset = 8'h01;

  // irq bits
  localparam int irq_width = 5;
  localparam int irq_mode_bit = 0;
  localparam int irq_invalid_bit = 1;
  localparam int irq_wake_bit = 2;
  localparam int irq_disc_bit = 3;
  localparam int irq_charge_bit = 4;
  localparam logic [irq_width-1:0] irq_mask_reset = 5'h00;

  // regen drag in percent of maximum, signed
  localparam logic signed [7:0] regen_none = 8'sh00;
  localparam logic signed [7:0] regen_rev = -8'sd50;
  localparam logic signed [7:0] regen_drive = 8'sh32;
  localparam logic signed [7:0] regen_low = 8'sh4b;
  localparam logic signed [7:0] regen_max = 8'sh64;

  // rpm limits; zero means no limit
  localparam logic [15:0] rpm_none = 16'h0000;
  localparam logic [15:0] rpm_rev = 16'h03e8;
  localparam logic [15:0] rpm_drive = 16'h2328;
  localparam logic [15:0] rpm_low_reset = 16'h0000;
  localparam logic [15:0] rpm_maxregen_reset = 16'h0000;

  localparam logic [7:0] accel_full = 8'hff;

  typedef enum logic [2:0] {
    dms_park, dms_reverse, dms_neutral, dms_drive, dms_low, dms_maxregen, dms_invalid
  } dms_mode_type;

  typedef enum {dms_off, dms_motoring, dms_charging, dms_disconnected} dms_state_type;

  typedef struct packed {
    logic signed [7:0] regen;
    logic brake_en;
    logic accel_en;
    logic ramp_down;
    logic [15:0] rpm_limit;
  } dms_setting_type;

endpackage

/* File: dms_top_properties.sv */
// port-level checks for the drive mode selector
// assumes switch lines synchronous to pclk and presetn active low
`timescale 1ns/1ps
module dms_top_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // switches
  input wire logic gear_code_bit_a,
  input wire logic gear_code_bit_b,
  input wire logic gear_code_bit_c,
  input wire logic gear_code_parity,
  input wire logic key_wake_in,
  input wire logic charge_port_present,
  input wire logic emergency_disconnect,
  // drive outputs
  input wire logic motoring_enable,
  input wire logic charging_enable,
  input wire logic ac_charge_allow,
  input wire logic propulsion_enable,
  input wire logic signed [7:0] regen_drag,
  input wire logic brake_torque_en,
  input wire logic [7:0] accel_torque_limit,
  input wire logic [15:0] rpm_limit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] sel;
  assign sel = {gear_code_bit_a, gear_code_bit_b, gear_code_bit_c, gear_code_parity};
  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_park_torque: assert property ((sel == 4'hf)[*3] |-> !brake_torque_en
    && accel_torque_limit == 8'h00 && regen_drag == 8'sh00) else $error("park torque on");
  chk_drive_limits: assert property (((sel == 4'ha) && motoring_enable)[*3] |->
    regen_drag == 8'sh32 && rpm_limit == 16'h2328) else $error("drive limits wrong");
  chk_reverse_limits: assert property (((sel == 4'h6) && motoring_enable)[*3] |->
    regen_drag == -8'sd50 && rpm_limit == 16'h03e8) else $error("reverse limits wrong");
  chk_invalid_park: assert property ((^sel)[*3] |-> !brake_torque_en
    && accel_torque_limit == 8'h00) else $error("odd parity not parked");
  chk_disc_power: assert property (emergency_disconnect |=> !propulsion_enable
    && !motoring_enable) else $error("power left on at disconnect");
  chk_key_off: assert property (!key_wake_in |=> !motoring_enable)
    else $error("motoring with key off");
  chk_key_wake: assert property ((!key_wake_in && !emergency_disconnect
    && !charge_port_present)[*2] ##1 (key_wake_in && !emergency_disconnect
    && !charge_port_present) |=> motoring_enable) else $error("no wake on key");
  chk_charge_override: assert property (charging_enable |-> !motoring_enable
    && !propulsion_enable) else $error("motoring while charging");
  chk_ac_allow: assert property (ac_charge_allow |-> charging_enable
    && !$past(key_wake_in) && $past(sel) == 4'hf) else $error("ac charge not parked");
endmodule
bind dms_top dms_top_properties dms_top_properties_inst (.pclk, .presetn, .psel, .penable,
  .pready, .gear_code_bit_a, .gear_code_bit_b, .gear_code_bit_c, .gear_code_parity,
  .key_wake_in, .charge_port_present, .emergency_disconnect, .motoring_enable,
  .charging_enable, .ac_charge_allow, .propulsion_enable, .regen_drag, .brake_torque_en,
  .accel_torque_limit, .rpm_limit);

/* File: dms_switch_model.sv */
// harness model: selector, key, charge port and disconnect lines
// assumes requested positions change just after pclk rising edges
`timescale 1ns/1ps
module dms_switch_model (
  // clock
  input wire logic pclk,
  // requested positions {a,b,c,p,key,port,disc}
  input wire logic [6:0] want,
  // harness lines
  output logic [6:0] lines
);
  // lines start grounded: no charger fitted, disconnect held at ground
  logic [6:0] lines_q = 7'h00;
  assign lines = lines_q;
  always @(posedge pclk) begin
    lines_q <= want;
  end
endmodule

/* File: drive_mode_selector_tb.sv */
// self-checking bench for the drive mode selector
// assumes the switch model and the bound checker are compiled alongside
`timescale 1ns/1ps
module drive_mode_selector_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, look_now = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, me, ce, aca, pe, brk, irq;
  logic signed [7:0] regen;
  logic [7:0] accel;
  logic [15:0] rpm;
  logic [6:0] sw = 7'h00, ln;
  logic [79:0] notes [$];
  int n_errors = 0, cmp_count = 0;
  always #2 pclk = ~pclk;
  dms_switch_model dms_switch_model_inst (.pclk(pclk), .want(sw), .lines(ln));
  dms_top #(.low_rpm_default(16'h0bb8), .maxregen_rpm_default(16'h1770)) dms_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gear_code_bit_a(ln[6]), .gear_code_bit_b(ln[5]), .gear_code_bit_c(ln[4]),
    .gear_code_parity(ln[3]), .key_wake_in(ln[2]), .charge_port_present(ln[1]),
    .emergency_disconnect(ln[0]), .motoring_enable(me), .charging_enable(ce),
    .ac_charge_allow(aca), .propulsion_enable(pe), .regen_drag(regen),
    .brake_torque_en(brk), .accel_torque_limit(accel), .rpm_limit(rpm), .irq(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [37:0] ex(input logic [7:0] r, input logic b,
      input logic [7:0] ac, input logic [15:0] lm, input logic [4:0] f);
    return {r, b, ac, lm, f};
  endfunction
  task automatic cmp(input logic [79:0] n, input logic [39:0] g);
    cmp_count++;
    if ((g & n[79:40]) !== (n[39:0] & n[79:40])) begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, g, n[39:0]);
    end
  endtask
  // read results are noted before the access edge, so the watcher pops in order
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) notes.push_back({40'hffffffffff, 7'h00, e});
    // no cycle count is assumed; a hang is ended by the watchdog
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic look(input logic [37:0] e, input logic [37:0] m);
    notes.push_back({2'b00, m, 2'b00, e});
    look_now <= 1'b1;
    @(posedge pclk);
    look_now <= 1'b0;
    @(posedge pclk);
  endtask
  // settle time covers the model edge plus the two-cycle settings lag
  task automatic go(input logic [6:0] v);
    sw <= v;
    repeat (6) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) cmp(notes.pop_front(), {7'h00, pslverr, prdata});
    if (look_now) cmp(notes.pop_front(), {2'b00, regen, brk, accel, rpm, me, ce, aca, pe, irq});
  end
  task automatic finish_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    finish_test();
  end
  initial begin
    logic [31:0] r;
    logic [3:0] cd [6];
    logic [7:0] rg [6];
    logic [7:0] ac [6];
    logic [15:0] lm [6];
    r = lfsr(32'hf2d5);
    cd = '{4'hf, 4'ha, 4'h3, 4'h6, 4'h9, 4'hc};
    rg = '{8'h00, 8'h32, 8'h00, 8'hce, 8'h4b, 8'h64};
    ac = '{8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff};
    lm = '{16'h0000, 16'h2328, 16'h0000, 16'h03e8, r[15:0], r[31:16]};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, dms_pkg::limits_addr, 32'h0, {1'b0, 32'h17700bb8});
    apb(1'b0, dms_pkg::irq_mask_addr, 32'h0, 33'h0);
    apb(1'b1, 12'h020, r, 33'h0);
    apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
    apb(1'b1, dms_pkg::limits_addr, r, 33'h0);
    apb(1'b0, dms_pkg::limits_addr, 32'h0, {1'b0, r});
    // full ramp step empties the neutral accel level in one cycle
    apb(1'b1, dms_pkg::ctrl_addr, 32'h0000ff00, 33'h0);
    for (int i = 0; i < 6; i++) begin
      go({cd[i], 3'b100});
      look(ex(rg[i], i != 0, ac[i], lm[i], 5'b10010), '1);
    end
    apb(1'b1, dms_pkg::irq_mask_addr, 32'h2, 33'h0);
    go({4'he, 3'b100});
    look(ex(8'h00, 1'b0, 8'h00, 16'h0, 5'b10011), '1);
    go({4'h5, 3'b100});
    look(ex(8'h00, 1'b0, 8'h00, 16'h0, 5'b10011), '1);
    go({4'hf, 3'b100});
    apb(1'b1, dms_pkg::irq_stat_addr, 32'h2, 33'h0);
    look(ex(8'h00, 1'b0, 8'h00, 16'h0, 5'b10010), '1);
    go({4'hf, 3'b010});
    look(ex(8'h00, 1'b0, 8'h00, 16'h0, 5'b01100), 38'h1f);
    go({4'hf, 3'b110});
    look(ex(8'h00, 1'b0, 8'h00, 16'h0, 5'b01000), 38'h1f);
    go({4'ha, 3'b000});
    go({4'ha, 3'b101});
    look(ex(8'h00, 1'b0, 8'h00, 16'h0, 5'b00000), 38'h1f);
    go({4'ha, 3'b100});
    look(ex(8'h00, 1'b0, 8'h00, 16'h0, 5'b00000), 38'h1f);
    go({4'ha, 3'b000});
    look(ex(8'h00, 1'b0, 8'h00, 16'h0, 5'b00000), 38'h1f);
    go({4'ha, 3'b100});
    look(ex(8'h32, 1'b1, 8'hff, 16'h2328, 5'b10010), '1);
    // a moving vehicle keeps motoring with the port present, then charges once stopped
    apb(1'b1, dms_pkg::ctrl_addr, 32'h0000ff01, 33'h0);
    apb(1'b0, dms_pkg::ctrl_addr, 32'h0, {1'b0, 32'h0000ff01});
    go({4'hf, 3'b110});
    look(ex(8'h00, 1'b0, 8'h00, 16'h0, 5'b10010), 38'h1f);
    apb(1'b1, dms_pkg::ctrl_addr, 32'h0000ff00, 33'h0);
    go({4'hf, 3'b110});
    look(ex(8'h00, 1'b0, 8'h00, 16'h0, 5'b01000), 38'h1f);
    finish_test();
  end
endmodule
